/* File: hdl/itr_pkg.sv */
// Shared constants and carrier types of the two-wire target register block.
// Assumes a system clock at 25 MHz and a link-side core clock at 8 MHz.
`default_nettype none
package itr_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL_PRIMARY = 8'h00;
  localparam logic [7:0] OFS_CONTROL_SECONDARY = 8'h04;
  localparam logic [7:0] OFS_IENCLR = 8'h14;
  localparam logic [7:0] OFS_IENSET = 8'h16;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1A;
  localparam logic [7:0] OFS_SYNC = 8'h1C;
  localparam logic [7:0] OFS_ADDR = 8'h24;
  localparam logic [7:0] OFS_DATA = 8'h28;
  // ==========================================================
  // Field positions
  localparam int CA_SOFT_RESET_BIT = 0;
  localparam int CA_EN = 1;
  localparam int CA_STDBY = 7;
  localparam int CA_CUMTO = 23;
  localparam int CA_SPEED = 24;
  localparam int CA_STRETCH_AFTER_ACK_SEL = 27;
  localparam int CA_LOWTO = 30;
  localparam int CB_AUTO_ACK_ON_READ = 8;
  localparam int CB_CMD = 16;
  localparam int CB_ACK_CHOICE = 18;
  localparam int IF_STOP = 0;
  localparam int IF_ADDR = 1;
  localparam int IF_BYTE = 2;
  localparam int IF_ERR = 7;
  // Status bits as seen in the word at the flags offset
  localparam int WS_DIR = 19;
  localparam int WS_LOWTO = 22;
  localparam int WS_CLKHOLD = 23;
  localparam int WS_EXTTO = 25;
  localparam int SY_SOFT_RESET_BIT = 0;
  localparam int SY_EN = 1;
  localparam int AD_OWN = 1;
  // ==========================================================
  // Write masks and reset values
  localparam logic [31:0] CONTROL_PRIMARY_WMASK = 32'h4BB1009F;
  localparam logic [31:0] CONTROL_PRIMARY_LIVE = 32'h00000003;
  localparam logic [31:0] CONTROL_SECONDARY_WMASK = 32'h0004C700;
  localparam logic [31:0] CONTROL_SECONDARY_LIVE = 32'h00040000;
  localparam logic [31:0] ADDR_WMASK = 32'h07FE87FF;
  localparam logic [7:0] IRQ_MASK = 8'h87;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] CMD_DATA = 2'h2;
  localparam logic [1:0] CMD_ADDR = 2'h3;
  localparam logic [1:0] SPEED_RSVD = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // ==========================================================
  // Time-out timing
  localparam int TOUT_MS = 25;
  localparam int LINK_HZ = 8000000;
  localparam int TOUT_CYC = (TOUT_MS * LINK_HZ + 999) / 1000;
  localparam int CNT_W = 20;
  // ==========================================================
  // Carriers across the clock boundary
  typedef struct packed {
    logic en;
    logic srst;
    logic after_ack_mode;
    logic ack_choice;
    logic drop;
    logic stuck_en;
    logic cum_en;
    logic [6:0] own_addr;
    logic rel_tog;
  } itr_cfg_t;
  typedef struct packed {
    logic en_echo;
    logic srst_echo;
    logic hold;
    logic dir;
    logic [7:0] rx_byte;
    logic addr_tog;
    logic byte_tog;
    logic stop_tog;
    logic low_tog;
    logic ext_tog;
  } itr_evt_t;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_HOLD, ST_ACK, ST_SKIP} itr_state_t;
endpackage
`default_nettype wire

/* File: hdl/itr_link.sv */
// Link-side logic of the target: wire sampling, byte receive, stretch and time-outs.
// Assumes clk_link is a free-running fixed core clock; cfg_in is quasi-static.
`default_nettype none
module itr_link #(
  parameter int TOUT_CYC = itr_pkg::TOUT_CYC
) (
  input wire logic clk_link,
  input wire logic rst_n,
  input wire itr_pkg::itr_cfg_t cfg_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_n,
  output logic sda_oe_n,
  output itr_pkg::itr_evt_t evt_out
);
  localparam logic [itr_pkg::CNT_W-1:0] TC = itr_pkg::CNT_W'(TOUT_CYC);
  // ==========================================================
  // Synchronisers
  itr_pkg::itr_cfg_t cfg_m_ff, cfg_ff;
  logic [1:0] scl_sy_ff, sda_sy_ff;
  logic scl_d_ff, sda_d_ff;
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      cfg_m_ff <= '0;
      cfg_ff <= '0;
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      cfg_m_ff <= cfg_in;
      cfg_ff <= cfg_m_ff;
      scl_sy_ff <= {scl_sy_ff[0], scl_in};
      sda_sy_ff <= {sda_sy_ff[0], sda_in};
      scl_d_ff <= scl_sy_ff[1];
      sda_d_ff <= sda_sy_ff[1];
    end
  end
  // ==========================================================
  // Transaction state
  itr_pkg::itr_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift, rx_ff, nxt_rx;
  logic is_addr_ff, nxt_is_addr, addressed_ff, nxt_addressed;
  logic after_ack_ff, nxt_after_ack, dir_ff, nxt_dir, frame_ff, nxt_frame;
  logic scl_oe_n_ff, nxt_scl_oe_n, sda_oe_n_ff, nxt_sda_oe_n, rel_d_ff, nxt_rel_d;
  logic [4:0] tog_ff, nxt_tog;
  logic [itr_pkg::CNT_W-1:0] low_ff, nxt_low, cum_ff, nxt_cum;
  logic scl, rise, fall, start, stop, release_ev, low_hit, ext_hit;
  always_comb begin
    scl = scl_sy_ff[1];
    rise = scl & ~scl_d_ff;
    fall = ~scl & scl_d_ff;
    start = scl & scl_d_ff & sda_d_ff & ~sda_sy_ff[1];
    stop = scl & scl_d_ff & ~sda_d_ff & sda_sy_ff[1];
    release_ev = cfg_ff.rel_tog ^ rel_d_ff;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_rx = rx_ff;
    nxt_is_addr = is_addr_ff;
    nxt_addressed = addressed_ff;
    nxt_after_ack = after_ack_ff;
    nxt_dir = dir_ff;
    nxt_frame = frame_ff;
    nxt_scl_oe_n = scl_oe_n_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    nxt_rel_d = cfg_ff.rel_tog;
    nxt_tog = tog_ff;
    // R16 fixed clock count
    // R5 continuous low
    low_hit = cfg_ff.stuck_en & ~scl & (low_ff == TC - 1'b1);
    nxt_low = (scl | ~cfg_ff.stuck_en) ? '0 : ((low_ff == TC) ? low_ff : low_ff + 1'b1);
    // R9 summed low
    ext_hit = cfg_ff.cum_en & frame_ff & ~scl & (cum_ff == TC - 1'b1);
    nxt_cum = cum_ff;
    if (cfg_ff.cum_en & frame_ff & ~scl & (cum_ff != TC)) begin
      nxt_cum = cum_ff + 1'b1;
    end
    case (state_ff)
      itr_pkg::ST_IDLE, itr_pkg::ST_SKIP: begin
      end
      itr_pkg::ST_RX: begin
        if (rise) begin
          nxt_shift = {shift_ff[6:0], sda_sy_ff[1]};
          nxt_cnt = cnt_ff + 1'b1;
        end
        if (fall && cnt_ff == itr_pkg::BYTE_BITS) begin
          // R14 drop when asleep
          if (is_addr_ff && (shift_ff[7:1] != cfg_ff.own_addr || cfg_ff.drop)) begin
            nxt_state = itr_pkg::ST_SKIP;
          end else begin
            if (is_addr_ff) begin
              nxt_addressed = 1'b1;
              nxt_dir = shift_ff[0];
              nxt_tog[4] = ~tog_ff[4];
            end else begin
              nxt_rx = shift_ff;
              nxt_tog[3] = ~tog_ff[3];
            end
            // R7 stretch point
            if (!cfg_ff.after_ack_mode) begin
              nxt_state = itr_pkg::ST_HOLD;
              nxt_after_ack = 1'b0;
              nxt_scl_oe_n = 1'b0;
            end else begin
              nxt_state = itr_pkg::ST_ACK;
              nxt_sda_oe_n = cfg_ff.ack_choice;
            end
          end
        end
      end
      itr_pkg::ST_HOLD: begin
        if (release_ev) begin
          nxt_scl_oe_n = 1'b1;
          nxt_cnt = 4'h0;
          nxt_is_addr = 1'b0;
          if (after_ack_ff) begin
            nxt_state = itr_pkg::ST_RX;
          end else begin
            nxt_state = itr_pkg::ST_ACK;
            nxt_sda_oe_n = cfg_ff.ack_choice;
          end
        end
      end
      itr_pkg::ST_ACK: begin
        if (fall) begin
          nxt_sda_oe_n = 1'b1;
          nxt_cnt = 4'h0;
          nxt_is_addr = 1'b0;
          // R7 stretch after ack
          if (cfg_ff.after_ack_mode) begin
            nxt_state = itr_pkg::ST_HOLD;
            nxt_after_ack = 1'b1;
            nxt_scl_oe_n = 1'b0;
          end else begin
            nxt_state = itr_pkg::ST_RX;
          end
        end
      end
      default: nxt_state = itr_pkg::ST_IDLE;
    endcase
    if (start) begin
      nxt_state = itr_pkg::ST_RX;
      nxt_cnt = 4'h0;
      nxt_is_addr = 1'b1;
      nxt_frame = 1'b1;
      nxt_cum = '0;
      nxt_sda_oe_n = 1'b1;
    end
    // R10 stop after time-out
    if (stop) begin
      nxt_state = itr_pkg::ST_IDLE;
      nxt_frame = 1'b0;
      nxt_cum = '0;
      nxt_sda_oe_n = 1'b1;
      nxt_scl_oe_n = 1'b1;
      nxt_addressed = 1'b0;
      if (addressed_ff) begin
        nxt_tog[2] = ~tog_ff[2];
      end
    end
    // R5 release and idle
    // R9 release and reset
    if (low_hit | ext_hit) begin
      nxt_state = itr_pkg::ST_IDLE;
      nxt_scl_oe_n = 1'b1;
      nxt_sda_oe_n = 1'b1;
      nxt_tog[1] = tog_ff[1] ^ low_hit;
      nxt_tog[0] = tog_ff[0] ^ ext_hit;
    end
    if (!cfg_ff.en || cfg_ff.srst) begin
      nxt_state = itr_pkg::ST_IDLE;
      nxt_scl_oe_n = 1'b1;
      nxt_sda_oe_n = 1'b1;
      nxt_frame = 1'b0;
      nxt_addressed = 1'b0;
      nxt_low = '0;
      nxt_cum = '0;
    end
  end
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= itr_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rx_ff <= 8'h00;
      is_addr_ff <= 1'b0;
      addressed_ff <= 1'b0;
      after_ack_ff <= 1'b0;
      dir_ff <= 1'b0;
      frame_ff <= 1'b0;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      rel_d_ff <= 1'b0;
      tog_ff <= 5'h00;
      low_ff <= '0;
      cum_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      rx_ff <= nxt_rx;
      is_addr_ff <= nxt_is_addr;
      addressed_ff <= nxt_addressed;
      after_ack_ff <= nxt_after_ack;
      dir_ff <= nxt_dir;
      frame_ff <= nxt_frame;
      scl_oe_n_ff <= nxt_scl_oe_n;
      sda_oe_n_ff <= nxt_sda_oe_n;
      rel_d_ff <= nxt_rel_d;
      tog_ff <= nxt_tog;
      low_ff <= nxt_low;
      cum_ff <= nxt_cum;
    end
  end
  assign scl_oe_n = scl_oe_n_ff;
  assign sda_oe_n = sda_oe_n_ff;
  assign evt_out = {cfg_ff.en, cfg_ff.srst, ~scl_oe_n_ff, dir_ff, rx_ff, tog_ff};
endmodule
`default_nettype wire

/* File: hdl/itr_regs.sv */
// Register file of the two-wire target, with the link-side unit beneath it.
// Assumes a byte-addressed register port with lane-aligned data and one access
// in flight; clk_link is an unrelated fixed clock.
//
// Behaviour
// R1 - Byte, halfword, word accesses all supported
// R2 - Every byte and halfword lane addressable
// R3 - Enable-protected fields ignore writes while enabled
// R4 - Access guard lock refuses protected writes
// R5 - Continuous SCL low 25 ms resets target
// R6 - Time-outs leave interrupt flags untouched; the code sets the error flag (bit 7) on either time-out
// R7 - Stretch mode picks hold point
// R8 - Two-bit speed field selects timing class
// R9 - Summed SCL low over 25 ms resets
// R10 - Stop still flagged after extended time-out
// R11 - Enable-clear, enable-set, flags share layout
// R12 - Soft reset clears registers, disables unit
// R13 - Enable reads back; busy until applied
// R14 - Sleeping without standby run drops receptions
// R15 - Smart mode acknowledges on data read
// R16 - Time-outs counted on fixed clock
`default_nettype none
module itr_regs #(
  parameter int TOUT_CYC = itr_pkg::TOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_link,
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic [7:0] bus_addr,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_err,
  output logic bus_done,
  input wire logic pac_lock,
  input wire logic standby_sleep,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_n,
  output logic sda_oe_n,
  output logic [1:0] speed_class
);
  // ==========================================================
  // Decode helpers
  function automatic logic [3:0] lanes_of(input logic [1:0] a, input logic [1:0] sz);
    case (sz)
      2'h0: lanes_of = 4'h1 << a;
      2'h1: lanes_of = a[0] ? 4'h0 : (4'h3 << a);
      2'h2: lanes_of = (a == 2'h0) ? 4'hF : 4'h0;
      default: lanes_of = 4'h0;
    endcase
  endfunction
  function automatic logic [31:0] mask_of(input logic [3:0] l);
    mask_of = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction
  // ==========================================================
  // Link side and crossing
  itr_pkg::itr_cfg_t cfg_ff, nxt_cfg;
  itr_pkg::itr_evt_t evt, evt_m_ff, evt_s_ff, evt_d_ff;
  itr_link #(
    .TOUT_CYC(TOUT_CYC)
  ) u_link (
    .clk_link(clk_link),
    .rst_n(rst_n),
    .cfg_in(cfg_ff),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n),
    .evt_out(evt)
  );
  // Events travel as toggles so a pulse cannot be missed across clocks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt_m_ff <= '0;
      evt_s_ff <= '0;
      evt_d_ff <= '0;
    end else begin
      evt_m_ff <= evt;
      evt_s_ff <= evt_m_ff;
      evt_d_ff <= evt_s_ff;
    end
  end
  logic e_addr, e_byte, e_stop, e_low, e_ext;
  assign e_addr = evt_s_ff.addr_tog ^ evt_d_ff.addr_tog;
  assign e_byte = evt_s_ff.byte_tog ^ evt_d_ff.byte_tog;
  assign e_stop = evt_s_ff.stop_tog ^ evt_d_ff.stop_tog;
  assign e_low = evt_s_ff.low_tog ^ evt_d_ff.low_tog;
  assign e_ext = evt_s_ff.ext_tog ^ evt_d_ff.ext_tog;
  // ==========================================================
  // Register state
  logic [31:0] control_primary_ff, nxt_control_primary, control_secondary_ff, nxt_control_secondary, addr_ff, nxt_addr;
  logic [7:0] inten_ff, nxt_inten, flags_ff, nxt_flags, tx_ff, nxt_tx;
  logic lowto_ff, nxt_lowto, extto_ff, nxt_extto;
  logic soft_reset_bit_ff, nxt_soft_reset_bit, en_busy_ff, nxt_en_busy, rel_ff, nxt_rel;
  logic [31:0] rdata_ff, nxt_rdata;
  logic err_ff, nxt_err, done_ff, nxt_done;
  logic [3:0] lanes;
  logic [31:0] bm, wm, rd, sts;
  logic wr, rdo, en_now, refused, flag_clr_cmd;
  logic [7:0] flag_set, flag_clr;
  always_comb begin
    // R1 access widths
    lanes = lanes_of(bus_addr[1:0], bus_size);
    // R2 lane masks
    bm = mask_of(lanes);
    wr = bus_sel & bus_write & (lanes != 4'h0);
    rdo = bus_sel & ~bus_write & (lanes != 4'h0);
    en_now = control_primary_ff[itr_pkg::CA_EN];
    nxt_control_primary = control_primary_ff;
    nxt_control_secondary = control_secondary_ff;
    nxt_addr = addr_ff;
    nxt_inten = inten_ff;
    nxt_tx = tx_ff;
    nxt_soft_reset_bit = soft_reset_bit_ff;
    nxt_rel = rel_ff;
    nxt_done = bus_sel;
    nxt_err = bus_sel & (lanes == 4'h0);
    flag_clr = 8'h00;
    flag_clr_cmd = 1'b0;
    wm = 32'h0;
    nxt_lowto = lowto_ff | e_low;
    nxt_extto = extto_ff | e_ext;
    // R4 guarded registers
    refused = pac_lock & (hit(bus_addr, itr_pkg::OFS_CONTROL_PRIMARY) |
              hit(bus_addr, itr_pkg::OFS_CONTROL_SECONDARY) | hit(bus_addr, itr_pkg::OFS_ADDR));
    if (wr && (soft_reset_bit_ff || refused)) begin
      nxt_err = 1'b1;
    end else if (wr) begin
      if (hit(bus_addr, itr_pkg::OFS_CONTROL_PRIMARY)) begin
        // R12 soft reset precedence
        if (lanes[0] && bus_wdata[itr_pkg::CA_SOFT_RESET_BIT]) begin
          nxt_soft_reset_bit = ~evt_s_ff.srst_echo;
        end else begin
          // R3 enable protection
          wm = en_now ? itr_pkg::CONTROL_PRIMARY_LIVE : itr_pkg::CONTROL_PRIMARY_WMASK;
          nxt_control_primary = merge(control_primary_ff, bus_wdata, bm & wm & ~32'h1);
          // R8 reserved speed kept out
          if (nxt_control_primary[itr_pkg::CA_SPEED +: 2] == itr_pkg::SPEED_RSVD) begin
            nxt_control_primary[itr_pkg::CA_SPEED +: 2] = control_primary_ff[itr_pkg::CA_SPEED +: 2];
          end
        end
      end
      if (hit(bus_addr, itr_pkg::OFS_CONTROL_SECONDARY)) begin
        // R3 enable protection
        wm = en_now ? itr_pkg::CONTROL_SECONDARY_LIVE : itr_pkg::CONTROL_SECONDARY_WMASK;
        nxt_control_secondary = merge(control_secondary_ff, bus_wdata, bm & wm);
        if (lanes[2] && (bus_wdata[itr_pkg::CB_CMD +: 2] == itr_pkg::CMD_DATA ||
            bus_wdata[itr_pkg::CB_CMD +: 2] == itr_pkg::CMD_ADDR)) begin
          nxt_rel = ~rel_ff;
          flag_clr_cmd = 1'b1;
        end
      end
      // R11 shared layout
      if (hit(bus_addr, itr_pkg::OFS_IENCLR)) begin
        if (lanes[0]) begin
          nxt_inten = inten_ff & ~(bus_wdata[7:0] & itr_pkg::IRQ_MASK);
        end
        if (lanes[2]) begin
          nxt_inten = nxt_inten | (bus_wdata[23:16] & itr_pkg::IRQ_MASK);
        end
      end
      if (hit(bus_addr, itr_pkg::OFS_FLAGS)) begin
        if (lanes[0]) begin
          flag_clr = bus_wdata[7:0] & itr_pkg::IRQ_MASK;
        end
        if (lanes[2] && bus_wdata[itr_pkg::WS_LOWTO]) begin
          nxt_lowto = e_low;
        end
        if (lanes[3] && bus_wdata[itr_pkg::WS_EXTTO]) begin
          nxt_extto = e_ext;
        end
      end
      if (hit(bus_addr, itr_pkg::OFS_ADDR) && !en_now) begin
        // R3 enable protection
        nxt_addr = merge(addr_ff, bus_wdata, bm & itr_pkg::ADDR_WMASK);
      end
      if (hit(bus_addr, itr_pkg::OFS_DATA) && lanes[0]) begin
        nxt_tx = bus_wdata[7:0];
      end
    end
    // R15 acknowledge on read
    if (rdo && !soft_reset_bit_ff && hit(bus_addr, itr_pkg::OFS_DATA) && lanes[0] &&
        control_secondary_ff[itr_pkg::CB_AUTO_ACK_ON_READ]) begin
      nxt_rel = ~rel_ff;
      flag_clr[itr_pkg::IF_BYTE] = 1'b1;
    end
    if (flag_clr_cmd) begin
      flag_clr[itr_pkg::IF_BYTE] = 1'b1;
      flag_clr[itr_pkg::IF_ADDR] = 1'b1;
      flag_clr[itr_pkg::IF_STOP] = 1'b1;
    end
    // R6 time-outs only set
    flag_set = 8'h00;
    flag_set[itr_pkg::IF_STOP] = e_stop;
    flag_set[itr_pkg::IF_ADDR] = e_addr;
    flag_set[itr_pkg::IF_BYTE] = e_byte;
    flag_set[itr_pkg::IF_ERR] = e_low | e_ext;
    // Set wins over clear so an event in the clearing cycle survives
    nxt_flags = (flags_ff & ~flag_clr) | flag_set;
    // R13 busy until applied
    nxt_en_busy = en_busy_ff;
    if (evt_s_ff.en_echo == control_primary_ff[itr_pkg::CA_EN]) begin
      nxt_en_busy = 1'b0;
    end
    if (wr && !soft_reset_bit_ff && !refused && hit(bus_addr, itr_pkg::OFS_CONTROL_PRIMARY) && lanes[0] &&
        !bus_wdata[itr_pkg::CA_SOFT_RESET_BIT]) begin
      nxt_en_busy = 1'b1;
    end
    // Status word as it sits at the flags offset
    sts = 32'h0;
    sts[itr_pkg::WS_DIR] = evt_s_ff.dir;
    sts[itr_pkg::WS_LOWTO] = lowto_ff;
    sts[itr_pkg::WS_CLKHOLD] = evt_s_ff.hold;
    sts[itr_pkg::WS_EXTTO] = extto_ff;
    rd = 32'h0;
    if (soft_reset_bit_ff) begin
      rd[itr_pkg::SY_SOFT_RESET_BIT] = hit(bus_addr, itr_pkg::OFS_CONTROL_PRIMARY) |
                              hit(bus_addr, itr_pkg::OFS_SYNC);
    end else if (hit(bus_addr, itr_pkg::OFS_CONTROL_PRIMARY)) begin
      rd = control_primary_ff;
    end else if (hit(bus_addr, itr_pkg::OFS_CONTROL_SECONDARY)) begin
      rd = control_secondary_ff;
    end else if (hit(bus_addr, itr_pkg::OFS_IENCLR)) begin
      rd = {8'h00, inten_ff, 8'h00, inten_ff};
    end else if (hit(bus_addr, itr_pkg::OFS_FLAGS)) begin
      rd = sts | {24'h0, flags_ff};
    end else if (hit(bus_addr, itr_pkg::OFS_SYNC)) begin
      rd[itr_pkg::SY_EN] = en_busy_ff;
    end else if (hit(bus_addr, itr_pkg::OFS_ADDR)) begin
      rd = addr_ff;
    end else if (hit(bus_addr, itr_pkg::OFS_DATA)) begin
      rd = {24'h0, evt_s_ff.rx_byte};
    end
    nxt_rdata = rdo ? (rd & bm) : 32'h0;
    // R12 reset completes
    if (soft_reset_bit_ff && evt_s_ff.srst_echo) begin
      nxt_soft_reset_bit = 1'b0;
      nxt_control_primary = itr_pkg::RST_WORD;
      nxt_control_secondary = itr_pkg::RST_WORD;
      nxt_addr = itr_pkg::RST_WORD;
      nxt_inten = itr_pkg::RST_BYTE;
      nxt_flags = itr_pkg::RST_BYTE;
      nxt_tx = itr_pkg::RST_BYTE;
      nxt_lowto = 1'b0;
      nxt_extto = 1'b0;
      nxt_en_busy = 1'b0;
    end
    // Levels handed to the link unit, registered before they cross
    nxt_cfg.en = nxt_control_primary[itr_pkg::CA_EN];
    nxt_cfg.srst = nxt_soft_reset_bit;
    nxt_cfg.after_ack_mode = nxt_control_primary[itr_pkg::CA_STRETCH_AFTER_ACK_SEL];
    nxt_cfg.ack_choice = nxt_control_secondary[itr_pkg::CB_ACK_CHOICE];
    // R14 drop in standby
    nxt_cfg.drop = standby_sleep & ~nxt_control_primary[itr_pkg::CA_STDBY];
    nxt_cfg.stuck_en = nxt_control_primary[itr_pkg::CA_LOWTO];
    nxt_cfg.cum_en = nxt_control_primary[itr_pkg::CA_CUMTO];
    nxt_cfg.own_addr = nxt_addr[itr_pkg::AD_OWN +: 7];
    nxt_cfg.rel_tog = nxt_rel;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      control_primary_ff <= itr_pkg::RST_WORD;
      control_secondary_ff <= itr_pkg::RST_WORD;
      addr_ff <= itr_pkg::RST_WORD;
      inten_ff <= itr_pkg::RST_BYTE;
      flags_ff <= itr_pkg::RST_BYTE;
      tx_ff <= itr_pkg::RST_BYTE;
      lowto_ff <= 1'b0;
      extto_ff <= 1'b0;
      soft_reset_bit_ff <= 1'b0;
      en_busy_ff <= 1'b0;
      rel_ff <= 1'b0;
      rdata_ff <= 32'h0;
      err_ff <= 1'b0;
      done_ff <= 1'b0;
      cfg_ff <= '0;
    end else begin
      control_primary_ff <= nxt_control_primary;
      control_secondary_ff <= nxt_control_secondary;
      addr_ff <= nxt_addr;
      inten_ff <= nxt_inten;
      flags_ff <= nxt_flags;
      tx_ff <= nxt_tx;
      lowto_ff <= nxt_lowto;
      extto_ff <= nxt_extto;
      soft_reset_bit_ff <= nxt_soft_reset_bit;
      en_busy_ff <= nxt_en_busy;
      rel_ff <= nxt_rel;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
      done_ff <= nxt_done;
      cfg_ff <= nxt_cfg;
    end
  end
  assign bus_rdata = rdata_ff;
  assign bus_err = err_ff;
  assign bus_done = done_ff;
  // R8 timing class out
  assign speed_class = control_primary_ff[itr_pkg::CA_SPEED +: 2];
endmodule
`default_nettype wire

/* File: testbench/itr_regs_assertions.sv */
// Port checks of the two-wire target register block.
// Assumes a bind onto itr_regs; sees its ports only.
`default_nettype none
module itr_regs_assertions #(parameter int TOUT_CYC = 200) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic [7:0] bus_addr,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_err,
  input wire logic bus_done,
  input wire logic pac_lock,
  input wire logic [1:0] speed_class
);
  // ==========
  // Bus answer
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_DONE: assert property (bus_sel |=> bus_done)
    else $error("request got no done");
  AST_IDLE: assert property (!bus_sel |=> !bus_done && !bus_err)
    else $error("done without request");
  AST_SIZE: assert property (bus_sel && bus_size == 2'h3 |=> bus_err)
    else $error("illegal size taken");
  AST_WORD: assert property (bus_sel && bus_size == 2'h2 && |bus_addr[1:0] |=> bus_err)
    else $error("misaligned word taken");
  AST_HALF: assert property (bus_sel && bus_size == 2'h1 && bus_addr[0] |=> bus_err)
    else $error("misaligned half taken");
  AST_LOCK: assert property (bus_sel && bus_write && pac_lock && bus_addr == 8'h04 |=> bus_err)
    else $error("locked write taken");
  AST_WZERO: assert property (bus_sel && bus_write |=> bus_rdata == 32'h0)
    else $error("write returned data");
  AST_SPEED: assert property (speed_class != 2'h3)
    else $error("reserved speed applied");
endmodule
`default_nettype wire

/* File: testbench/itr_host.sv */
// Behavioural two-wire bus host on the target's pins.
// Assumes pull-ups; target enables are low while it drives.
`default_nettype none
module itr_host (
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 2000;
  logic scl_h = 1'b1;
  logic sda_h = 1'b1;
  // Wired-and with pull-up, so a released line reads high
  assign scl = scl_h & scl_oe_n;
  assign sda = sda_h & sda_oe_n;
  task automatic start();
    sda_h = 1'b0;
    #HALF;
    scl_h = 1'b0;
    #HALF;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_h = b[i];
      #HALF;
      scl_h = 1'b1;
      #HALF;
      scl_h = 1'b0;
    end
    sda_h = 1'b1;
  endtask
  task automatic stop();
    sda_h = 1'b0;
    #HALF;
    scl_h = 1'b1;
    // A stretching target keeps the clock low; wait it out
    wait (scl);
    #HALF;
    sda_h = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_itr_regs.sv */
// Self-checking bench of the two-wire target register block.
// Assumes the host model on the wire and a short time-out count.
`default_nettype none
module tb_itr_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TOUT_CYC = 200;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n = 1'b0;
  logic bus_sel = 1'b0;
  logic bus_write = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [1:0] bus_size = 2'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic pac_lock = 1'b0;
  logic standby_sleep = 1'b0;
  logic [31:0] bus_rdata;
  logic [31:0] rd;
  logic [1:0] speed_class;
  logic bus_err, bus_done, scl_oe_n, sda_oe_n, scl_in, sda_in, er;
  int n_errors = 0;
  int tests_run = 0;
  always #20 clk_sys = ~clk_sys;
  always #62.5 clk_link = ~clk_link;
  itr_regs #(.TOUT_CYC(TOUT_CYC)) dut_u (.clk_sys, .rst_n, .clk_link, .bus_sel,
    .bus_write, .bus_addr, .bus_size, .bus_wdata, .bus_rdata, .bus_err, .bus_done,
    .pac_lock, .standby_sleep, .scl_in, .sda_in, .scl_oe_n, .sda_oe_n, .speed_class);
  itr_host host_u (.scl_oe_n, .sda_oe_n, .scl(scl_in), .sda(sda_in));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] s,
      input logic [31:0] d);
    @(posedge clk_sys);
    bus_sel <= 1'b1;
    bus_write <= w;
    bus_addr <= a;
    bus_size <= s;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_sel <= 1'b0;
    #1;
    rd = bus_rdata;
    er = bus_err;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [1:0] s, input logic [31:0] e);
    acc(1'b0, a, s, 32'h0);
    chk(rd, e);
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    #1000000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(8'h00, 2'h2, 32'h0);
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 8'h03, 2'h0, {6'h0, 2'(k), 24'h0});
      chk(32'(speed_class), (k < 3) ? k : 2);
    end
    rdchk(8'h03, 2'h0, 32'h02000000);
    acc(1'b0, 8'h01, 2'h2, 32'h0);
    chk(32'(er), 32'h1);
    acc(1'b0, 8'h01, 2'h1, 32'h0);
    chk(32'(er), 32'h1);
    acc(1'b0, 8'h00, 2'h3, 32'h0);
    chk(32'(er), 32'h1);
    acc(1'b1, 8'h16, 2'h0, 32'h00870000);
    rdchk(8'h14, 2'h0, 32'h87);
    acc(1'b1, 8'h14, 2'h0, 32'h05);
    rdchk(8'h16, 2'h0, 32'h00820000);
    @(posedge clk_sys);
    pac_lock <= 1'b1;
    acc(1'b1, 8'h04, 2'h2, 32'h00000100);
    chk(32'(er), 32'h1);
    pac_lock <= 1'b0;
    rdchk(8'h04, 2'h2, 32'h0);
    acc(1'b1, 8'h24, 2'h2, 32'hA0);
    acc(1'b1, 8'h00, 2'h2, 32'h40800000);
    acc(1'b1, 8'h00, 2'h2, 32'h40800002);
    rdchk(8'h00, 2'h2, 32'h40800002);
    rdchk(8'h1C, 2'h0, 32'h2);
    repeat (40) @(posedge clk_sys);
    rdchk(8'h1C, 2'h0, 32'h0);
    acc(1'b1, 8'h03, 2'h0, 32'h01000000);
    rdchk(8'h00, 2'h2, 32'h40800002);
    host_u.start();
    host_u.send(8'hA0);
    repeat (30) @(posedge clk_sys);
    chk(32'(scl_oe_n), 32'h0);
    chk(32'(sda_oe_n), 32'h1);
    rdchk(8'h18, 2'h0, 32'h02);
    repeat (800) @(posedge clk_sys);
    chk(32'(scl_oe_n), 32'h1);
    rdchk(8'h18, 2'h2, 32'h02400082);
    host_u.stop();
    // Stop crosses two synchronisers before the flag shows
    repeat (20) @(posedge clk_sys);
    rdchk(8'h18, 2'h0, 32'h83);
    acc(1'b1, 8'h18, 2'h2, 32'h02400087);
    rdchk(8'h18, 2'h2, 32'h0);
    acc(1'b1, 8'h00, 2'h0, 32'h01);
    rdchk(8'h1C, 2'h0, 32'h1);
    repeat (40) @(posedge clk_sys);
    rdchk(8'h00, 2'h2, 32'h0);
    rdchk(8'h24, 2'h2, 32'h0);
    give_verdict();
  end
endmodule
bind itr_regs itr_regs_assertions #(.TOUT_CYC(TOUT_CYC)) chk_u (.clk_sys, .rst_n, .bus_sel,
  .bus_write, .bus_addr, .bus_size, .bus_rdata, .bus_err, .bus_done, .pac_lock, .speed_class);
`default_nettype wire
